// File: src/adccc_top.sv
// Conversion control top: AHB-Lite registers, trigger logic, done flag and interrupt
// Assumes one AHB-Lite master, single word transfers, hardware trigger from another domain
//
// Behaviour
// - Any write to the status/control register aborts a running conversion and, with trigger select clear, starts anew unless the channel is all ones.
// - The done flag is read-only and, with compare off, is set at the end of every conversion that does not end in the cycle of a status/control write.
// - With compare on, the done flag is set at the end of a conversion only when the compare holds.
// - The done flag clears on any write to the status/control register and on a read of the low result unless a conversion sets it in that cycle.
// - An interrupt is raised when the done flag becomes set while the interrupt enable and the done mask bit are one.
// - With continuous clear, exactly one conversion follows each write of a channel other than all ones (software) or each trigger rise while idle (hardware).
// - With continuous set, conversions repeat one idle cycle apart after a write or a hardware trigger event.
// - Bits 4:0 select inputs 0..27, a reserved code, the high reference or the low reference.
// - Channel code all ones powers the converter off and isolates the input.
// - Writing the all-ones code to stop continuous conversion produces no further conversion.
// - With continuous off the converter returns to low-power idle after each conversion.
// - The trigger select bit chooses register write (clear) or hardware trigger rise (set) as start.
// - The active bit is set when a conversion starts and cleared when it completes or is aborted without a restart in the same cycle.
`timescale 1ns/10ps
module adccc_top
  import adccc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Converter side
  input  wire logic        hardware_trigger_in,
  input  wire logic [11:0] sample_in,
  output logic             converter_power,
  output logic [4:0]       channel_select_out,
  output logic             conversion_active,
  // Interrupt
  output logic             irq
);

  default clocking adccc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic              done_flag;
    logic              done_ie;
    logic              continuous;
    logic [4:0]        channel;
    logic              trig_sel;
    logic              cmp_en;
    logic              cmp_gt;
    logic [RES_W-1:0]  result;
    logic [RES_W-1:0]  compare;
    logic              armed;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [1:0]        trig_sync;
    logic              trig_last;
    logic [31:0]       rdata;
  } adccc_regs_t;

  adccc_regs_t r;
  adccc_regs_t next_r;
  adccc_conv_if cv ();

  adccc_sequencer u_seq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .cv        (cv.seq),
    .sample_in (sample_in)
  );

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  logic       addr_ok;
  logic       rd_req;
  logic       sc_write;
  logic       trig_rise;
  logic       cmp_true;
  logic       set_done;
  logic       rl_read;
  logic       do_start;
  logic       do_abort;
  logic       off;
  logic [4:0] wr_ch;

  always_comb begin
    next_r    = r;
    addr_ok   = hsel && hready && htrans[1];
    rd_req    = addr_ok && !hwrite;
    sc_write  = r.wr_pend && (r.wr_addr == OFF_STATUS_CONTROL);
    wr_ch     = hwdata[4:0];
    rl_read   = rd_req && (haddr == OFF_RESULT_LOW);
    trig_rise = r.trig_sync[1] && !r.trig_last;
    cmp_true  = r.cmp_gt ? (cv.result >= r.compare) : (cv.result < r.compare);
    set_done  = cv.done && (!r.cmp_en || cmp_true);
    off       = (r.channel == CH_DISABLED);
    do_abort  = sc_write && cv.busy;
    do_start  = 1'b0;

    next_r.wr_pend   = addr_ok && hwrite;
    next_r.wr_addr   = haddr;
    next_r.trig_sync = {r.trig_sync[0], hardware_trigger_in};
    next_r.trig_last = r.trig_sync[1];

    if (sc_write) begin
      next_r.done_ie    = hwdata[BIT_DONE_IE];
      next_r.continuous = hwdata[BIT_CONTINUOUS];
      next_r.channel    = wr_ch;
      next_r.armed      = (wr_ch != CH_DISABLED);
      if (!r.trig_sel && wr_ch != CH_DISABLED) begin
        do_start = 1'b1;
      end
    end
    if (r.wr_pend && r.wr_addr == OFF_CONTROL2) begin
      next_r.trig_sel = hwdata[BIT_TRIG_SEL];
      next_r.cmp_en   = hwdata[BIT_CMP_EN];
      next_r.cmp_gt   = hwdata[BIT_CMP_GT];
    end
    if (r.wr_pend && r.wr_addr == OFF_COMPARE) begin
      next_r.compare = hwdata[RES_W-1:0];
    end
    if (r.wr_pend && r.wr_addr == OFF_IRQ_MASK) begin
      next_r.irq_mask = hwdata[IRQ_W-1:0];
    end
    if (r.wr_pend && r.wr_addr == OFF_IRQ_STATUS) begin
      next_r.irq_status = r.irq_status & ~hwdata[IRQ_W-1:0];
    end

    // Hardware trigger: one conversion per rise while idle (a rise during a conversion is ignored), or starts a continuous run
    if (r.trig_sel && trig_rise && !off && !cv.busy && !sc_write) begin
      do_start = 1'b1;
    end
    // Continuous repeat once armed by a write or trigger
    if (cv.done && r.continuous && !off && !sc_write && (!r.trig_sel || r.armed)) begin
      do_start = 1'b1;
    end
    if (r.trig_sel && trig_rise && !off) begin
      next_r.armed = 1'b1;
    end

    // Done flag: clear by write or low-result read; set wins over the read, the write wins over set
    if (sc_write || rl_read) begin
      next_r.done_flag = 1'b0;
    end
    if (set_done && !sc_write) begin
      next_r.done_flag = 1'b1;
      next_r.result    = cv.result;
    end

    if (set_done && !sc_write && r.done_ie) begin
      next_r.irq_status[IRQ_DONE] = 1'b1;
    end
    if (do_abort) begin
      next_r.irq_status[IRQ_ABORT] = 1'b1;
    end

    next_r.rdata = '0;
    if (rd_req) begin
      case (haddr)
        OFF_STATUS_CONTROL: next_r.rdata = {24'h00_0000, next_r.done_flag, r.done_ie, r.continuous, r.channel};
        OFF_CONTROL2:       next_r.rdata = {24'h00_0000, cv.busy, r.trig_sel, r.cmp_en, r.cmp_gt, 4'h0};
        OFF_RESULT_LOW:     next_r.rdata = {20'h0_0000, r.result};
        OFF_COMPARE:        next_r.rdata = {20'h0_0000, r.compare};
        OFF_IRQ_STATUS:     next_r.rdata = {30'h0000_0000, r.irq_status};
        OFF_IRQ_MASK:       next_r.rdata = {30'h0000_0000, r.irq_mask};
        default:            next_r.rdata = '0;
      endcase
    end
  end

  assign cv.start   = do_start;
  assign cv.abort   = do_abort;
  assign cv.channel = r.channel;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r            <= '0;
      r.channel    <= SC_RESET[4:0];
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata             = r.rdata;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign irq                = |(r.irq_status & r.irq_mask);
  assign converter_power    = cv.busy && !off;
  assign channel_select_out = off ? CH_DISABLED : r.channel;
  assign conversion_active  = cv.busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_sc_write;
    sc_write && wr_ch != CH_DISABLED && !r.trig_sel;
  endsequence

  property p_write_starts;
    @(posedge hclk) disable iff (!hresetn) s_sc_write |=> cv.busy;
  endproperty
  a_write_starts: assert property (p_write_starts) else $error("Write did not start conversion");

  property p_done_nocmp;
    @(posedge hclk) disable iff (!hresetn) (cv.done && !r.cmp_en && !sc_write) |=> r.done_flag;
  endproperty
  a_done_nocmp: assert property (p_done_nocmp) else $error("Done flag not set");

  property p_done_cmp;
    @(posedge hclk) disable iff (!hresetn) (cv.done && r.cmp_en && !cmp_true && !r.done_flag) |=> !r.done_flag;
  endproperty
  a_done_cmp: assert property (p_done_cmp) else $error("Done flag set on false compare");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn) (sc_write && !set_done) |=> !r.done_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("Done flag not cleared by write");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn) (set_done && !sc_write && r.done_ie) |=> r.irq_status[IRQ_DONE];
  endproperty
  a_irq: assert property (p_irq) else $error("Done interrupt missing");

  property p_single;
    @(posedge hclk) disable iff (!hresetn) (cv.done && !r.continuous && !sc_write && !trig_rise) |=> !cv.busy;
  endproperty
  a_single: assert property (p_single) else $error("Extra single conversion");

  property p_off_idle;
    @(posedge hclk) disable iff (!hresetn) (sc_write && wr_ch == CH_DISABLED) |=> !cv.busy;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Conversion after disable code");

  property p_active;
    (cv.start |=> conversion_active) and ((cv.abort && !cv.start) |=> !conversion_active);
  endproperty
  a_active: assert property (p_active) else $error("Active bit wrong after start or abort");

  property p_abort_idle;
    (sc_write && cv.busy && (wr_ch == CH_DISABLED || r.trig_sel)) |=> !cv.busy;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("Abort left converter busy");

  property p_abort_flag;
    do_abort |=> r.irq_status[IRQ_ABORT];
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("Abort event not recorded");

  property p_done_cmp_true;
    (cv.done && r.cmp_en && cmp_true && !sc_write) |=> r.done_flag;
  endproperty
  a_done_cmp_true: assert property (p_done_cmp_true) else $error("Done flag missing on true compare");

  property p_result_hold;
    !set_done |=> $stable(r.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("Result changed without counted conversion");

  property p_read_clear;
    (rl_read && !set_done) |=> !r.done_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Done flag not cleared by result read");

  property p_irq_noie;
    (!r.irq_status[IRQ_DONE] && !(set_done && r.done_ie)) |=> !r.irq_status[IRQ_DONE];
  endproperty
  a_irq_noie: assert property (p_irq_noie) else $error("Done interrupt without enabled flag set");

  property p_irq_clear;
    (r.wr_pend && r.wr_addr == OFF_IRQ_STATUS && hwdata[IRQ_DONE] && !set_done)
      |=> !r.irq_status[IRQ_DONE];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Done interrupt not cleared");

  property p_irq_level;
    (r.irq_status[IRQ_DONE] && r.irq_mask[IRQ_DONE]) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt line low with pending event");

  property p_mode_write;
    sc_write |=> (r.done_ie == $past(hwdata[BIT_DONE_IE])) && (r.continuous == $past(hwdata[BIT_CONTINUOUS]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Mode bits not taken from write");

  property p_cont_soft;
    (cv.done && r.continuous && !off && !sc_write && !r.trig_sel) |=> cv.busy;
  endproperty
  a_cont_soft: assert property (p_cont_soft) else $error("Continuous run did not repeat");

  property p_cont_hw;
    (cv.done && r.continuous && !off && !sc_write && r.armed) |=> cv.busy;
  endproperty
  a_cont_hw: assert property (p_cont_hw) else $error("Armed continuous run did not repeat");

  property p_hw_start;
    (r.trig_sel && trig_rise && !off && !cv.busy && !sc_write) |=> cv.busy;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("Trigger did not start conversion");

  property p_hw_nowrite;
    (sc_write && r.trig_sel && !cv.busy) |=> !cv.busy;
  endproperty
  a_hw_nowrite: assert property (p_hw_nowrite) else $error("Write started conversion in trigger mode");

  property p_channel_write;
    sc_write |=> (r.channel == $past(wr_ch));
  endproperty
  a_channel_write: assert property (p_channel_write) else $error("Channel not taken from write");

  property p_off_quiet;
    (off && !sc_write) |=> !cv.busy;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Conversion while disabled");

  property p_low_power;
    (cv.done && !r.continuous && !sc_write && !trig_rise) |=> !converter_power;
  endproperty
  a_low_power: assert property (p_low_power) else $error("Power kept after single conversion");

  localparam int DONE_WAIT = CONV_CYCLES + 1;

  sequence s_conv_end;
    cv.done || cv.abort;
  endsequence

  property p_done_within;
    (cv.start && !cv.busy) |-> ##[1:DONE_WAIT] s_conv_end;
  endproperty
  a_done_within: assert property (p_done_within) else $error("Conversion did not end in time");

  property p_rdata_idle;
    !rd_req |=> (hrdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside a read");

endmodule

// File: src/adccc_pkg.sv
// Package: register map, field layout, reset values and timing of the conversion control block
// Assumes a 32-bit AHB-Lite register bus, one aligned word per register
package adccc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONTROL2       = 8'h04;
  localparam logic [7:0] OFF_RESULT_LOW     = 8'h08;
  localparam logic [7:0] OFF_COMPARE        = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DONE_FLAG  = 7;
  localparam int BIT_DONE_IE    = 6;
  localparam int BIT_CONTINUOUS = 5;
  localparam int BIT_ACTIVE     = 7;
  localparam int BIT_TRIG_SEL   = 6;
  localparam int BIT_CMP_EN     = 5;
  localparam int BIT_CMP_GT     = 4;
  localparam int RES_W          = 12;
  localparam int IRQ_W          = 2;
  localparam int IRQ_DONE       = 0;
  localparam int IRQ_ABORT      = 1;

  // ----------------------------------------------------------------
  // Channel codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CH_LAST_INPUT = 5'h1B;
  localparam logic [4:0] CH_RESERVED   = 5'h1C;
  localparam logic [4:0] CH_HIGH_REF   = 5'h1D;
  localparam logic [4:0] CH_LOW_REF    = 5'h1E;
  localparam logic [4:0] CH_DISABLED   = 5'h1F;
  localparam logic [7:0] SC_RESET      = 8'h1F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 250;
  localparam int CONV_NS     = 80;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W       = 8;

  typedef enum logic [1:0] {ADCCC_IDLE, ADCCC_CONVERT} adccc_state_t;

endpackage

// File: src/adccc_conv_if.sv
// Interface: start/abort request and completion report between control and sequencer
// Assumes both ends run on hclk
`timescale 1ns/10ps
interface adccc_conv_if;
  logic       start;
  logic       abort;
  logic [4:0] channel;
  logic       busy;
  logic       done;
  logic [11:0] result;
  modport ctrl (output start, output abort, output channel, input busy, input done, input result);
  modport seq  (input start, input abort, input channel, output busy, output done, output result);
endinterface

// File: src/adccc_sequencer.sv
// Conversion sequencer: times one conversion and captures the sample at its end
// Assumes the analog core presents a settled sample on sample_in
`timescale 1ns/10ps
module adccc_sequencer
  import adccc_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control side
  adccc_conv_if.seq       cv,
  // Analog core
  input  wire logic [11:0] sample_in
);

  typedef struct packed {
    adccc_state_t     state;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic [11:0]      result;
  } adccc_seq_t;

  adccc_seq_t r;
  adccc_seq_t next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      ADCCC_IDLE: begin
        if (cv.start) begin
          next_r.state = ADCCC_CONVERT;
          next_r.cnt   = CNT_W'(CONV_CYCLES - 1);
        end
      end
      ADCCC_CONVERT: begin
        if (cv.abort) begin
          next_r.state = ADCCC_IDLE;
          if (cv.start) begin
            next_r.state = ADCCC_CONVERT;
            next_r.cnt   = CNT_W'(CONV_CYCLES - 1);
          end
        end else if (r.cnt == '0) begin
          next_r.state  = ADCCC_IDLE;
          next_r.done   = 1'b1;
          next_r.result = sample_in;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: next_r.state = ADCCC_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{ADCCC_IDLE, '0, 1'b0, '0};
    end else begin
      r <= next_r;
    end
  end

  assign cv.busy   = (r.state == ADCCC_CONVERT);
  assign cv.done   = r.done;
  assign cv.result = r.result;

endmodule

// File: verification/adccc_far_side.sv
// Far-side model: hardware trigger source and analog sample level
// Assumes bench commands arrive in the hclk domain
`timescale 1ns/10ps
module adccc_far_side (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench commands
  input  wire logic        fire,
  input  wire logic [3:0]  delay,
  input  wire logic [11:0] level,
  // Toward the block
  output logic             hardware_trigger_in,
  output logic [11:0]      sample_in
);
  // ----------------------------------------------------------------
  // Trigger pulse after a chosen delay, three cycles wide
  // ----------------------------------------------------------------
  logic [4:0] count;

  assign sample_in           = level;
  assign hardware_trigger_in = (count != 5'h00) && (count <= 5'h03);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 5'h00;
    end else if (fire) begin
      count <= {1'b0, delay} + 5'h04;
    end else if (count != 5'h00) begin
      count <= count - 5'h01;
    end
  end
endmodule

// File: verification/test_adc_conversion_control.sv
// Testbench: register accesses over AHB-Lite with expected values
// Assumes adccc_top and adccc_far_side; one 250 MHz clock
`timescale 1ns/10ps
module test_adc_conversion_control
  import adccc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        hardware_trigger_in;
  logic [11:0] sample_in;
  logic        converter_power;
  logic [4:0]  channel_select_out;
  logic        conversion_active;
  logic        irq;
  logic        fire;
  logic [3:0]  delay;
  logic [11:0] level;
  logic [31:0] rd;
  int          fail_count;
  int          check_count;

  adccc_top adccc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hardware_trigger_in(hardware_trigger_in), .sample_in(sample_in),
    .converter_power(converter_power), .channel_select_out(channel_select_out),
    .conversion_active(conversion_active), .irq(irq)
  );

  adccc_far_side adccc_far_side_inst (
    .hclk(hclk), .hresetn(hresetn), .fire(fire), .delay(delay), .level(level),
    .hardware_trigger_in(hardware_trigger_in), .sample_in(sample_in)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  task automatic wait_act(input logic lvl, input int limit);
    int n;
    n = 0;
    while (conversion_active !== lvl && n < limit) begin
      @(posedge hclk);
      n++;
    end
    check("active", 32'(conversion_active), 32'(lvl));
  endtask

  task automatic run_one();
    wait_act(1'b1, 10);
    wait_act(1'b0, 40);
    cyc(3);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #40000;
    fail_count++;
    stop_test();
  end

  initial begin
    logic [4:0] codes [5];
    codes = '{CH_LAST_INPUT, CH_RESERVED, CH_HIGH_REF, CH_LOW_REF, 5'h00};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    fire = 1'b0;
    delay = 4'h2;
    level = 12'h5A5;
    fail_count = 0;
    check_count = 0;
    cyc(6);
    hresetn <= 1'b1;
    rchk("status reset", OFF_STATUS_CONTROL, 32'(SC_RESET));
    check("power off", 32'(converter_power), 32'h0000_0000);
    check("channel off", 32'(channel_select_out), 32'(CH_DISABLED));
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    check("okay", 32'(hresp), 32'h0000_0000);
    check("ready", 32'(hreadyout), 32'h0000_0001);
    foreach (codes[i]) begin
      bus(1'b1, OFF_STATUS_CONTROL, 32'(codes[i]));
      cyc(2);
      check("channel", 32'(channel_select_out), 32'(codes[i]));
    end
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_001F);
    cyc(2);
    check("stopped", 32'(conversion_active), 32'h0000_0000);
    bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0003);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0003);
    // Single conversion with interrupt
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0045);
    run_one();
    rchk("done set", OFF_STATUS_CONTROL, 32'h0000_00C5);
    check("irq high", 32'(irq), 32'h0000_0001);
    rchk("irq status", OFF_IRQ_STATUS, 32'h0000_0001);
    rchk("result", OFF_RESULT_LOW, 32'h0000_05A5);
    rchk("done cleared", OFF_STATUS_CONTROL, 32'h0000_0045);
    bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0001);
    cyc(2);
    check("irq low", 32'(irq), 32'h0000_0000);
    check("single idle", 32'(conversion_active), 32'h0000_0000);
    check("low power", 32'(converter_power), 32'h0000_0000);
    // Abort in mid conversion
    level <= 12'h123;
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0006);
    wait_act(1'b1, 10);
    cyc(5);
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0007);
    cyc(2);
    check("restart", 32'(conversion_active), 32'h0000_0001);
    check("new channel", 32'(channel_select_out), 32'h0000_0007);
    rchk("abort event", OFF_IRQ_STATUS, 32'(1) << IRQ_ABORT);
    check("abort irq", 32'(irq), 32'h0000_0001);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
    cyc(2);
    check("masked", 32'(irq), 32'h0000_0000);
    wait_act(1'b0, 40);
    cyc(3);
    rchk("abort done", OFF_STATUS_CONTROL, 32'h0000_0087);
    rchk("no done irq", OFF_IRQ_STATUS, 32'(1) << IRQ_ABORT);
    bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0003);
    // Continuous conversion then stop
    level <= 12'h111;
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0025);
    wait_act(1'b1, 10);
    cyc(22);
    level <= 12'h222;
    cyc(44);
    rchk("repeat result", OFF_RESULT_LOW, 32'h0000_0222);
    check("still active", 32'(conversion_active), 32'h0000_0001);
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_001F);
    cyc(2);
    check("off active", 32'(conversion_active), 32'h0000_0000);
    check("off power", 32'(converter_power), 32'h0000_0000);
    cyc(50);
    check("no extra", 32'(conversion_active), 32'h0000_0000);
    rchk("no extra flag", OFF_STATUS_CONTROL, 32'h0000_001F);
    bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0003);
    // Compare function, greater or equal
    bus(1'b1, OFF_CONTROL2, 32'h0000_0030);
    bus(1'b1, OFF_COMPARE, 32'h0000_0800);
    level <= 12'h100;
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0001);
    run_one();
    rchk("compare false", OFF_STATUS_CONTROL, 32'h0000_0001);
    level <= 12'h900;
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0001);
    run_one();
    rchk("compare true", OFF_STATUS_CONTROL, 32'h0000_0081);
    rchk("control2", OFF_CONTROL2, 32'h0000_0030);
    // Hardware trigger
    bus(1'b1, OFF_CONTROL2, 32'h0000_0040);
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0002);
    cyc(10);
    check("write no start", 32'(conversion_active), 32'h0000_0000);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    wait_act(1'b1, 20);
    wait_act(1'b0, 40);
    cyc(30);
    check("one hw conv", 32'(conversion_active), 32'h0000_0000);
    rchk("hw done", OFF_STATUS_CONTROL, 32'h0000_0082);
    // Hardware-triggered continuous run, then disable code
    level <= 12'h333;
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_0022);
    cyc(10);
    check("hw wait", 32'(conversion_active), 32'h0000_0000);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    wait_act(1'b1, 20);
    cyc(25);
    level <= 12'h444;
    cyc(25);
    rchk("hw repeat", OFF_RESULT_LOW, 32'h0000_0444);
    bus(1'b1, OFF_STATUS_CONTROL, 32'h0000_001F);
    cyc(2);
    check("hw stop", 32'(conversion_active), 32'h0000_0000);
    bus(1'b1, OFF_CONTROL2, 32'h0000_0000);
    stop_test();
  end
endmodule
